// file: cpsr_pkg.sv
// constants and types for the cable plug status responder
// assumes a protocol layer outside that frames, checks and retries messages
//
// Behaviour
// - discover modes reply echoes the sixteen-bit svid named in the request
// - discover modes reply header declares four data objects: vdm header plus three modes
// - every get_status addressed to the plug while it is idle is answered with a status message
// - status sent for sop' or sop'' reports the plug's own condition
// - status is extended, data size two bytes, two-byte status block
// - byte zero is temperature: 0 unsupported, 1 below two, else degrees
// - byte one bit zero is thermal shutdown, bits one to seven zero
// - every svid is a sixteen-bit unsigned identifier
package cpsr_pkg;
    typedef enum logic [1:0]
    {
        CPSR_SOP = 2'b00,
        CPSR_SOP_PRIME = 2'b01,
        CPSR_SOP_DPRIME = 2'b10
    } cpsr_sop_t;

    typedef enum logic [1:0]
    {
        CPSR_REQ_NONE = 2'b00,
        CPSR_REQ_DISC_MODES = 2'b01,
        CPSR_REQ_GET_STATUS = 2'b10
    } cpsr_req_t;

    typedef enum logic [1:0]
    {
        CPSR_RSP_NONE = 2'b00,
        CPSR_RSP_MODES = 2'b01,
        CPSR_RSP_STATUS = 2'b10
    } cpsr_rsp_t;

    localparam logic [2:0] CPSR_MODES_OBJ_COUNT = 3'h4;
    localparam logic [4:0] CPSR_STATUS_DATA_SIZE = 5'h02;
    localparam logic [7:0] CPSR_TEMP_UNSUPPORTED = 8'h00;
    localparam logic [7:0] CPSR_TEMP_BELOW_TWO = 8'h01;
    localparam logic [7:0] CPSR_TEMP_MIN_DEGREES = 8'h02;
    localparam int CPSR_SVID_WIDTH = 16;
    localparam int CPSR_MODE_COUNT = 3;
endpackage : cpsr_pkg

// file: cpsr_mode_table.sv
// small table of mode objects, one row per supported svid
// assumes the table contents are fixed at build time; read data is registered
`timescale 1ns/10ps
module cpsr_mode_table
#(
    parameter int ENTRIES = 2,
    parameter logic [ENTRIES*16-1:0] SVIDS = {16'h0000, 16'h0000},
    parameter logic [ENTRIES*96-1:0] MODES = '0
)
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [15:0] i_svid,
    output logic o_hit,
    output logic [95:0] o_modes
);
    import cpsr_pkg::*;

    typedef struct packed
    {
        logic hit;
        logic [95:0] modes;
    } cpsr_tab_state_t;

    cpsr_tab_state_t state;
    cpsr_tab_state_t next_state;
    logic [ENTRIES-1:0] match;

    if (ENTRIES < 1)
    begin : g_entries_check
        $error("mode table needs at least one entry");
    end

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++)
        begin : g_match
            assign match[g] = (SVIDS[g*16 +: 16] == i_svid) && (i_svid != 16'h0000);
        end
    endgenerate

    always_comb
    begin
        next_state = '0;
        for (int k = 0; k < ENTRIES; k++)
        begin
            if (match[k] && !next_state.hit)
            begin
                next_state.hit = 1'b1;
                next_state.modes = MODES[k*96 +: 96];
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            state <= '0;
        else
            state <= next_state;
    end

    assign o_hit = state.hit;
    assign o_modes = state.modes;
endmodule : cpsr_mode_table

// file: cpsr_responder.sv
// request decoder and reply builder for the cable plug
// assumes the protocol layer delivers one decoded request pulse at a time
`timescale 1ns/10ps
module cpsr_responder
#(
    parameter int ENTRIES = 2,
    // arbitrary svids; real ones are set per cable at build time
    parameter logic [ENTRIES*16-1:0] SVIDS = {16'h3c4d, 16'h1a2b},
    parameter logic [ENTRIES*96-1:0] MODES = '0
)
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire cpsr_pkg::cpsr_req_t i_req_kind,
    input wire cpsr_pkg::cpsr_sop_t i_req_sop,
    input wire logic [15:0] i_req_svid,
    input wire logic [7:0] i_temp,
    input wire logic i_thermal_shutdown,
    input wire logic i_rsp_ready,
    output logic o_rsp_valid,
    output cpsr_pkg::cpsr_rsp_t o_rsp_kind,
    output cpsr_pkg::cpsr_sop_t o_rsp_sop,
    output logic [2:0] o_rsp_obj_count,
    output logic [4:0] o_rsp_data_size,
    output logic [15:0] o_rsp_svid,
    output logic o_rsp_nak,
    output logic [95:0] o_rsp_modes,
    output logic [15:0] o_rsp_status
);
    import cpsr_pkg::*;

    typedef enum logic [1:0]
    {
        CPSR_IDLE = 2'b00,
        CPSR_LOOKUP = 2'b01,
        CPSR_SEND = 2'b10
    } cpsr_state_t;

    typedef struct packed
    {
        cpsr_state_t fsm;
        logic valid;
        cpsr_rsp_t kind;
        cpsr_sop_t sop;
        logic [2:0] obj_count;
        logic [4:0] data_size;
        logic [15:0] svid;
        logic nak;
        logic [95:0] modes;
        logic [15:0] status;
    } cpsr_core_t;

    cpsr_core_t state;
    cpsr_core_t next_state;
    logic tab_hit;
    logic [95:0] tab_modes;
    logic cable_req;
    logic [7:0] temp_code;

    // the reply layout is fixed at sixteen-bit svids and three mode words
    if (CPSR_SVID_WIDTH != 16 || CPSR_MODE_COUNT != 3)
    begin : g_layout_check
        $error("svid or mode count layout unsupported");
    end

    if (ENTRIES < 1)
    begin : g_entries_check
        $error("mode table needs at least one entry");
    end

    cpsr_mode_table #(
        .ENTRIES(ENTRIES),
        .SVIDS(SVIDS),
        .MODES(MODES)
    ) u_table (
        .i_clock(i_clock),
        .i_reset(i_reset),
        // looked up at the taking edge so the registered answer is ready in lookup
        .i_svid(i_req_svid),
        .o_hit(tab_hit),
        .o_modes(tab_modes)
    );

    // requests on plain sop belong to the port partner, not to this plug
    assign cable_req = (i_req_sop == CPSR_SOP_PRIME) || (i_req_sop == CPSR_SOP_DPRIME);

    // sensor may report 0 or 1 raw; 0 stays unsupported, 1 reads as below two, two and up pass as degrees
    assign temp_code = (i_temp == CPSR_TEMP_UNSUPPORTED) ? CPSR_TEMP_UNSUPPORTED
        : (i_temp < CPSR_TEMP_MIN_DEGREES) ? CPSR_TEMP_BELOW_TWO : i_temp;

    always_comb
    begin
        next_state = state;
        case (state.fsm)
            CPSR_IDLE:
            begin
                if (i_req_valid && cable_req)
                begin
                    // kind none latches nothing, so a refused request leaves no trace
                    if (i_req_kind == CPSR_REQ_DISC_MODES)
                    begin
                        next_state.fsm = CPSR_LOOKUP;
                        next_state.sop = i_req_sop;
                        next_state.svid = i_req_svid;
                    end
                    else if (i_req_kind == CPSR_REQ_GET_STATUS)
                    begin
                        next_state.fsm = CPSR_SEND;
                        next_state.sop = i_req_sop;
                        next_state.svid = i_req_svid;
                        next_state.valid = 1'b1;
                        next_state.kind = CPSR_RSP_STATUS;
                        next_state.obj_count = 3'h0;
                        next_state.data_size = CPSR_STATUS_DATA_SIZE;
                        next_state.nak = 1'b0;
                        next_state.modes = '0;
                        // plug's own sensor, never a partner's status
                        next_state.status = {7'h00, i_thermal_shutdown, temp_code};
                    end
                end
            end
            CPSR_LOOKUP:
            begin
                // table registered its answer at the taking edge
                next_state.fsm = CPSR_SEND;
                next_state.valid = 1'b1;
                next_state.kind = CPSR_RSP_MODES;
                next_state.obj_count = CPSR_MODES_OBJ_COUNT;
                next_state.data_size = 5'h00;
                next_state.nak = !tab_hit;
                next_state.modes = tab_modes;
                next_state.status = 16'h0000;
            end
            CPSR_SEND:
            begin
                if (i_rsp_ready)
                begin
                    next_state.fsm = CPSR_IDLE;
                    next_state.valid = 1'b0;
                end
            end
            default:
                next_state.fsm = CPSR_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            state <= '0;
        else
            state <= next_state;
    end

    assign o_rsp_valid = state.valid;
    assign o_rsp_kind = state.kind;
    assign o_rsp_sop = state.sop;
    assign o_rsp_obj_count = state.obj_count;
    assign o_rsp_data_size = state.data_size;
    assign o_rsp_svid = state.svid;
    assign o_rsp_nak = state.nak;
    assign o_rsp_modes = state.modes;
    assign o_rsp_status = state.status;

    chk_status_answered: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && cable_req && i_req_kind == CPSR_REQ_GET_STATUS)
        |=> o_rsp_valid && o_rsp_kind == CPSR_RSP_STATUS)
        else $error("get_status not answered");

    chk_status_size: assert property (@(posedge i_clock) disable iff (i_reset)
        o_rsp_valid && o_rsp_kind == CPSR_RSP_STATUS |-> o_rsp_data_size == 5'h02)
        else $error("status data size wrong");

    chk_status_objects: assert property (@(posedge i_clock) disable iff (i_reset)
        o_rsp_valid && o_rsp_kind == CPSR_RSP_STATUS |-> o_rsp_obj_count == 3'h0)
        else $error("status reply declares data objects");

    chk_flags_reserved: assert property (@(posedge i_clock) disable iff (i_reset)
        o_rsp_valid && o_rsp_kind == CPSR_RSP_STATUS |-> o_rsp_status[15:9] == 7'h00)
        else $error("status reserved flags set");

    chk_temp_value: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && cable_req && i_req_kind == CPSR_REQ_GET_STATUS)
        |=> o_rsp_status[7:0] == (($past(i_temp) == 8'h01) ? 8'h01 : $past(i_temp))
            && o_rsp_status[8] == $past(i_thermal_shutdown))
        else $error("status temperature or shutdown wrong");

    chk_mode_count: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && cable_req && i_req_kind == CPSR_REQ_DISC_MODES)
        |=> ##1 o_rsp_valid && o_rsp_kind == CPSR_RSP_MODES && o_rsp_obj_count == 3'h4)
        else $error("discover modes reply missing or wrong count");

    chk_svid_echo: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && cable_req && i_req_kind == CPSR_REQ_DISC_MODES)
        |=> ##1 o_rsp_svid == $past(i_req_svid, 2))
        else $error("svid not echoed");

    chk_same_sop: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && cable_req && i_req_kind != CPSR_REQ_NONE)
        |=> o_rsp_sop == $past(i_req_sop))
        else $error("reply on wrong packet type");

    chk_sop_ignored: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && i_req_sop == CPSR_SOP) |=> !o_rsp_valid)
        else $error("answered a request for the port partner");

    chk_plug_only: assert property (@(posedge i_clock) disable iff (i_reset)
        o_rsp_valid |-> o_rsp_sop != CPSR_SOP)
        else $error("reply on plain sop");

    chk_kind_none: assert property (@(posedge i_clock) disable iff (i_reset)
        (state.fsm == CPSR_IDLE && i_req_valid && i_req_kind == CPSR_REQ_NONE)
        |=> !o_rsp_valid && $stable(o_rsp_sop) && $stable(o_rsp_svid))
        else $error("request of kind none left a trace");

    chk_hold_reply: assert property (@(posedge i_clock) disable iff (i_reset)
        o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_status))
        else $error("reply dropped before ready");

    chk_reply_taken: assert property (@(posedge i_clock) disable iff (i_reset)
        o_rsp_valid && i_rsp_ready |=> !o_rsp_valid)
        else $error("reply still shown after it was taken");

    chk_reset_quiet: assert property (@(posedge i_clock)
        i_reset |=> !o_rsp_valid && o_rsp_status == 16'h0000 && o_rsp_modes == '0)
        else $error("reply outputs not cleared by reset");

    cov_status: cover property (@(posedge i_clock) o_rsp_valid && o_rsp_kind == CPSR_RSP_STATUS);
    cov_modes_hit: cover property (@(posedge i_clock) o_rsp_valid && !o_rsp_nak
        && o_rsp_kind == CPSR_RSP_MODES);
    cov_modes_nak: cover property (@(posedge i_clock) o_rsp_valid && o_rsp_nak);
    cov_shutdown: cover property (@(posedge i_clock) o_rsp_valid && o_rsp_status[8]);
    cov_stalled: cover property (@(posedge i_clock) o_rsp_valid && !i_rsp_ready ##1 o_rsp_valid);
endmodule : cpsr_responder

// file: cpsr_port_model.sv
// port controller model: issues requests to the plug and takes replies
// assumes the responder holds its reply until ready is seen high
`timescale 1ns/10ps
module cpsr_port_model
(
    input wire logic i_clock,
    input wire logic i_rsp_valid,
    output logic o_req_valid,
    output cpsr_pkg::cpsr_req_t o_req_kind,
    output cpsr_pkg::cpsr_sop_t o_req_sop,
    output logic [15:0] o_req_svid,
    output logic o_rsp_ready
);
    import cpsr_pkg::*;
    initial
    begin
        o_req_valid = 1'b0;
        o_req_kind = CPSR_REQ_NONE;
        o_req_sop = CPSR_SOP;
        o_req_svid = 16'h0000;
        o_rsp_ready = 1'b0;
    end
    // lat counts edges from the taking edge; 8 means no reply came
    task automatic request(input cpsr_req_t kind, input cpsr_sop_t sop,
        input logic [15:0] svid, input int stall, output int lat);
    begin
        @(negedge i_clock);
        o_req_valid = 1'b1;
        o_req_kind = kind;
        o_req_sop = sop;
        o_req_svid = svid;
        @(negedge i_clock);
        o_req_valid = 1'b0;
        o_req_kind = CPSR_REQ_NONE;
        // released svid lines do not keep the old value
        o_req_svid = ~svid;
        lat = 1;
        while (i_rsp_valid !== 1'b1 && lat < 8)
        begin
            @(negedge i_clock);
            lat++;
        end
        if (lat < 8)
        begin
            repeat (stall) @(negedge i_clock);
            o_rsp_ready = 1'b1;
        end
    end
    endtask : request
    task automatic take;
    begin
        @(negedge i_clock);
        o_rsp_ready = 1'b0;
    end
    endtask : take
endmodule : cpsr_port_model

// file: test_cable_plug_status_responder.sv
// self-checking bench for the plug responder with a port controller model
// assumes a one-row mode table so the mode words are known
`timescale 1ns/10ps
module test_cable_plug_status_responder;
    import cpsr_pkg::*;
    localparam logic [95:0] MODE_WORDS = 96'hc0de_0003_b0b0_0002_a5a5_0001;
    localparam logic [15:0] TABLE_SVID = 16'h5a3c; // arbitrary svid for the one table row
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_req_valid, i_rsp_ready, i_thermal_shutdown = 1'b0;
    cpsr_req_t i_req_kind;
    cpsr_sop_t i_req_sop;
    logic [15:0] i_req_svid;
    logic [7:0] i_temp = 8'h00;
    logic o_rsp_valid, o_rsp_nak;
    cpsr_rsp_t o_rsp_kind;
    cpsr_sop_t o_rsp_sop;
    logic [2:0] o_rsp_obj_count;
    logic [4:0] o_rsp_data_size;
    logic [15:0] o_rsp_svid, o_rsp_status;
    logic [95:0] o_rsp_modes;
    int mismatches = 0;
    int num_checks = 0;
    int lat;

    always #20 i_clock = ~i_clock;

    cpsr_responder #(.ENTRIES(1), .SVIDS(TABLE_SVID), .MODES(MODE_WORDS)) cpsr_responder_i
    (
        .i_clock(i_clock), .i_reset(i_reset), .i_req_valid(i_req_valid),
        .i_req_kind(i_req_kind), .i_req_sop(i_req_sop), .i_req_svid(i_req_svid),
        .i_temp(i_temp), .i_thermal_shutdown(i_thermal_shutdown),
        .i_rsp_ready(i_rsp_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_kind(o_rsp_kind),
        .o_rsp_sop(o_rsp_sop), .o_rsp_obj_count(o_rsp_obj_count),
        .o_rsp_data_size(o_rsp_data_size), .o_rsp_svid(o_rsp_svid),
        .o_rsp_nak(o_rsp_nak), .o_rsp_modes(o_rsp_modes), .o_rsp_status(o_rsp_status)
    );
    cpsr_port_model cpsr_port_model_i
    (
        .i_clock(i_clock), .i_rsp_valid(o_rsp_valid), .o_req_valid(i_req_valid),
        .o_req_kind(i_req_kind), .o_req_sop(i_req_sop), .o_req_svid(i_req_svid),
        .o_rsp_ready(i_rsp_ready)
    );

    task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    end
    endtask : check

    task automatic end_sim;
    begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask : end_sim

    task automatic t_status;
        logic [7:0] temps [4];
        cpsr_sop_t sop;
    begin
        temps = '{8'h00, 8'h01, 8'h02, 8'hff};
        for (int i = 0; i < 4; i++)
        begin
            @(negedge i_clock);
            i_temp = temps[i];
            i_thermal_shutdown = i[0];
            sop = i[1] ? CPSR_SOP_DPRIME : CPSR_SOP_PRIME;
            cpsr_port_model_i.request(CPSR_REQ_GET_STATUS, sop, 16'h1234, i, lat);
            check(lat, 1, "status latency");
            check(o_rsp_kind, CPSR_RSP_STATUS, "status kind");
            check(o_rsp_sop, sop, "status sop");
            check(o_rsp_data_size, 5'h02, "data size");
            check(o_rsp_obj_count, 3'h0, "status object count");
            check(o_rsp_status[7:0], temps[i], "temperature byte");
            check(o_rsp_status[15:8], {7'h00, i[0]}, "flag byte");
            cpsr_port_model_i.take();
            check(o_rsp_valid, 1'b0, "valid after take");
        end
        $display("status test done");
    end
    endtask : t_status

    task automatic t_modes;
        logic [15:0] svids [2];
    begin
        svids = '{TABLE_SVID, 16'hffff};
        for (int i = 0; i < 2; i++)
        begin
            cpsr_port_model_i.request(CPSR_REQ_DISC_MODES,
                i ? CPSR_SOP_PRIME : CPSR_SOP_DPRIME, svids[i], 2 - i, lat);
            check(lat, 2, "modes latency");
            check(o_rsp_kind, CPSR_RSP_MODES, "modes kind");
            check(o_rsp_sop, i ? CPSR_SOP_PRIME : CPSR_SOP_DPRIME, "modes sop");
            check(o_rsp_obj_count, 3'h4, "object count");
            check(o_rsp_data_size, 5'h00, "modes data size");
            check(o_rsp_svid, svids[i], "echoed svid");
            check(o_rsp_nak, i[0], "nak flag");
            if (i == 0)
                check(o_rsp_modes, MODE_WORDS, "mode words");
            cpsr_port_model_i.take();
        end
        $display("modes test done");
    end
    endtask : t_modes

    task automatic t_refuse;
    begin
        // plain sop belongs to the port partner, not the plug
        cpsr_port_model_i.request(CPSR_REQ_GET_STATUS, CPSR_SOP, 16'h0000, 0, lat);
        check(lat, 8, "plain sop ignored");
        cpsr_port_model_i.request(CPSR_REQ_NONE, CPSR_SOP_PRIME, 16'h0000, 0, lat);
        check(lat, 8, "kind none ignored");
        check(o_rsp_svid, 16'hffff, "refused request leaves reply fields");
        $display("refuse test done");
    end
    endtask : t_refuse

    task automatic t_reset;
    begin
        // reset lands while a status reply is still waiting for ready
        fork
            cpsr_port_model_i.request(CPSR_REQ_GET_STATUS, CPSR_SOP_PRIME, 16'h0000, 4, lat);
            begin
                @(posedge o_rsp_valid);
                @(negedge i_clock);
                i_reset = 1'b1;
                @(negedge i_clock);
                check(o_rsp_valid, 1'b0, "valid in reset");
                check({o_rsp_kind, o_rsp_status}, 18'h0_0000, "reply cleared in reset");
                i_reset = 1'b0;
                @(negedge i_clock);
                check(o_rsp_valid, 1'b0, "valid after reset release");
            end
        join
        cpsr_port_model_i.take();
        check(lat, 1, "status latency before reset");
        $display("reset test done");
    end
    endtask : t_reset

    initial
    begin
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        i_reset = 1'b0;
        check(o_rsp_valid, 1'b0, "valid after reset");
        t_status();
        t_modes();
        t_refuse();
        t_reset();
        t_status();
        end_sim();
    end

    // whole run is under a hundred cycles
    initial
    begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule : test_cable_plug_status_responder
